// File: design/dual_port_pkg.sv
package dual_port_pkg;

    // ****************************************************************
    // Bus shape, register map and bit positions
    // ****************************************************************
    localparam int             DATA_W = 16;
    localparam int             ADDR_W = 5;
    localparam logic [4:0]     ADDR_CONTROL_ONE       = 5'h00;
    localparam logic [4:0]     ADDR_DRIVE_STATUS      = 5'h01;
    localparam logic [4:0]     ADDR_ATTENTION_SUMMARY = 5'h04;
    localparam int             GO_BIT   = 0;
    localparam int             FUNC_LSB = 1;
    localparam int             FUNC_W   = 5;
    localparam int             VV_BIT   = 6;
    localparam int             DRY_BIT  = 7;
    localparam int             DPR_BIT  = 8;
    localparam int             PGM_BIT  = 9;
    localparam int             DVA_BIT  = 11;
    localparam int             MOL_BIT  = 12;
    localparam int             ATA_BIT  = 15;

    // ****************************************************************
    // Function codes and selector encoding
    // ****************************************************************
    localparam logic [4:0]     CMD_RELEASE        = 5'h05;
    localparam logic [4:0]     CMD_READ_IN_PRESET = 5'h08;
    localparam logic [4:0]     CMD_PACK_ACK       = 5'h09;
    localparam logic [1:0]     SELECT_A           = 2'h1;
    localparam logic [1:0]     SELECT_B           = 2'h2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint         CLK_PERIOD_NS     = 10;
    localparam longint         RELEASE_TIMEOUT_S = 1;
    localparam longint         RELEASE_TIMEOUT_CYCLES =
        RELEASE_TIMEOUT_S * 64'd1_000_000_000 / CLK_PERIOD_NS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_PROG   = 2'b00,
        MODE_LOCK_A = 2'b01,
        MODE_LOCK_B = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_A    = 2'b01,
        OWN_B    = 2'b10
    } owner_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_t;

    typedef struct packed {
        logic              ack;
        logic              parity;
        logic [DATA_W-1:0] data;
    } ans_t;

    localparam mode_t  RST_MODE  = MODE_PROG;
    localparam owner_t RST_OWNER = OWN_NONE;

endpackage

// File: design/dual_port_drive_arbiter.sv
`timescale 1ns/1ps
// Behaviour
// - Port selector sampled only on the not-ready to ready edge, picks mode.
// - Locked mode answers only the locked port; other port gets nothing.
// - Programmable mode answers both ports, subject to seizure state.
// - Selector changes after ready are ignored until the next restart.
// - Programmable mode is always owned by A, owned by B, or neutral.
// - Non-owner may use attention summary; other writes dropped, reads zero, parity one.
// - Neutral drive is granted to the first port with a qualifying access.
// - Separate volume-valid flag per port, each seen only by its port at bit 06.
// - Pack acknowledge and read-in preset set only the issuing port's volume-valid.
// - Ready bit 07 is the inverse of go: cleared at start, set at completion.
// - Non-owner status read returns zeros with normal acknowledge; looks busy.
// - Drive-present bit 08 reads one to the owner, zero to the other.
// - Bit 09 is one when programmable, zero when locked; one until online.
// - Attention bit 15 backed by two per-port flops, each port sees its own.
// - Control bit 11 device available reads one to owner, zero to other.
// - Release returns to neutral, or hands to the other port if it requested.
// - Accepted initialize clears only that port's attention flop.
// - Initialize from the non-owning port is ignored while owned.
// - Neutral accepts initialize from either port; it clears other state normally.
// - Neutral seizes on any non-summary write, control read, or own-bit summary write.
// - Non-owner control write is dropped but sets that port's request flop.
// - Owner idle one second without release drops ownership; not when locked.
// - Handover to a requesting port sets its attention flop and line.
module dual_port_drive_arbiter
    import dual_port_pkg::*;
#(
    parameter longint     TIMEOUT_CYCLES = RELEASE_TIMEOUT_CYCLES,
    parameter logic [3:0] UNIT           = 4'h0
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire req_t       A_REQ,
    input  wire req_t       B_REQ,
    input  wire logic       A_INIT,
    input  wire logic       B_INIT,
    input  wire logic [1:0] PORT_SELECT,
    input  wire logic       DRIVE_READY,
    input  wire logic       MEDIUM_ONLINE,
    input  wire logic       OP_DONE,
    output ans_t            A_ANS,
    output ans_t            B_ANS,
    output logic            A_ATTENTION_LINE,
    output logic            B_ATTENTION_LINE,
    output logic            GO,
    output logic [4:0]      FUNCTION
);

    // The timer is only as wide as the chosen timeout needs, so a shortened
    // timeout for a quick bench run also shrinks the counter.
    localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);

    initial begin
        if (TIMEOUT_CYCLES < 2 || UNIT > 4'h7) begin
            $error("dual_port_drive_arbiter: TIMEOUT_CYCLES or UNIT out of range");
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    req_t       req_m_q [2];
    req_t       req_s_q [2];
    logic [1:0] vld_prev_q;
    logic [1:0] init_m_q, init_s_q, init_prev_q;
    logic [1:0] sel_m_q, sel_s_q;
    logic [1:0] rdy_m_q;
    logic [1:0] rdy_s_q;
    logic       mol_m_q, mol_s_q;

    // Every pin input but OP_DONE, CE and RST passes two flops before logic reads it.
    // The request struct is synchronised as a whole, so the controller must hold
    // address and data steady for three cycles before raising valid; otherwise a
    // field could be caught half-way through its change.
    // The ready line gets one extra stage so that its edge detector compares two
    // already settled samples.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            req_m_q     <= '{default: '0};
            req_s_q     <= '{default: '0};
            vld_prev_q  <= 2'h0;
            init_m_q    <= 2'h0;
            init_s_q    <= 2'h0;
            init_prev_q <= 2'h0;
            sel_m_q     <= 2'h0;
            sel_s_q     <= 2'h0;
            rdy_m_q     <= 2'h0;
            rdy_s_q     <= 2'h0;
            mol_m_q     <= 1'b0;
            mol_s_q     <= 1'b0;
        end else if (CE) begin
            req_m_q     <= '{A_REQ, B_REQ};
            req_s_q     <= req_m_q;
            vld_prev_q  <= {req_s_q[1].valid, req_s_q[0].valid};
            init_m_q    <= {B_INIT, A_INIT};
            init_s_q    <= init_m_q;
            init_prev_q <= init_s_q;
            sel_m_q     <= PORT_SELECT;
            sel_s_q     <= sel_m_q;
            rdy_m_q     <= {rdy_m_q[0], DRIVE_READY};
            rdy_s_q     <= {rdy_s_q[0], rdy_m_q[1]};
            mol_m_q     <= MEDIUM_ONLINE;
            mol_s_q     <= mol_m_q;
        end
    end

    // ****************************************************************
    // Core state
    // ****************************************************************
    mode_t            mode_q, mode_d;
    owner_t           owner_q, owner_d;
    logic             go_q, go_d;
    logic [4:0]       func_q, func_d;
    logic [1:0]       vv_q, vv_d;
    logic [1:0]       attention_line_q, attention_line_d;
    logic [1:0]       want_q, want_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    ans_t             ans_q [2];
    ans_t             ans_d [2];

    // ****************************************************************
    // Per-port decode
    // ****************************************************************
    logic [1:0] strobe, qual, heard, owner_is, grant, owns;
    logic [1:0] own_cs_wr, release_req, vv_set, want_set, init_acc, attention_line_clr;
    logic [1:0] handed;
    logic       prog, neutral, rdy_rise, drop, timeout_hit, owner_touch, init_any;
    logic       pgm_bit;

    assign prog     = mode_q == MODE_PROG;
    assign neutral  = owner_q == OWN_NONE;
    assign rdy_rise = rdy_s_q[0] & ~rdy_s_q[1];
    assign pgm_bit  = ~mol_s_q | prog;

    // Read word builder. A port that does not own the drive sees only its own
    // attention bit in the summary register; every other read comes back as zero.
    // Unimplemented addresses read as zero even to the owner.
    function automatic logic [DATA_W-1:0] rd_word(
        input logic       own,
        input logic [4:0] addr,
        input logic       attention_line,
        input logic       vv
    );
        logic [DATA_W-1:0] w;
        w = '0;
        if (addr == ADDR_ATTENTION_SUMMARY) begin
            w[UNIT[2:0]] = attention_line;
        end else if (own && addr == ADDR_CONTROL_ONE) begin
            w[DVA_BIT]                 = 1'b1;
            w[FUNC_LSB +: FUNC_W]      = func_q;
            w[GO_BIT]                  = go_q;
        end else if (own && addr == ADDR_DRIVE_STATUS) begin
            w[ATA_BIT] = attention_line;
            w[MOL_BIT] = mol_s_q;
            w[PGM_BIT] = pgm_bit;
            w[DPR_BIT] = 1'b1;
            w[DRY_BIT] = ~go_q;
            w[VV_BIT]  = vv;
        end
        return w;
    endfunction

    for (genvar p = 0; p < 2; p++) begin : g_port
        wire logic             wr    = req_s_q[p].write;
        wire logic [4:0]       addr  = req_s_q[p].addr;
        wire logic [15:0]      data  = req_s_q[p].data;
        wire logic             is_cs = addr == ADDR_CONTROL_ONE;
        wire logic             is_as = addr == ADDR_ATTENTION_SUMMARY;
        wire logic [4:0]       fn    = data[FUNC_LSB +: FUNC_W];
        wire logic             is_lk = mode_q == ((p == 0) ? MODE_LOCK_A : MODE_LOCK_B);
        wire logic [DATA_W-1:0] rd   = rd_word(owns[p], addr, attention_line_q[p], vv_q[p]);

        assign strobe[p]   = req_s_q[p].valid & ~vld_prev_q[p];
        assign heard[p]    = prog | is_lk;
        assign qual[p]     = strobe[p] & (wr ? (~is_as | data[UNIT[2:0]]) : is_cs);
        assign owner_is[p] = owner_q == ((p == 0) ? OWN_A : OWN_B);
        assign owns[p]     = owner_is[p] | grant[p];
        assign own_cs_wr[p]   = strobe[p] & wr & is_cs & owns[p] & heard[p];
        assign release_req[p] = own_cs_wr[p] & prog & (fn == CMD_RELEASE);
        assign vv_set[p]      = own_cs_wr[p] & data[GO_BIT]
                              & (fn == CMD_PACK_ACK | fn == CMD_READ_IN_PRESET);
        assign want_set[p]    = prog & ~owns[p]
                              & ((strobe[p] & wr & is_cs) | (neutral & qual[p]));
        assign init_acc[p]    = init_s_q[p] & ~init_prev_q[p] & heard[p]
                              & (owner_is[p] | neutral);
        assign attention_line_clr[p]    = init_acc[p]
                              | (strobe[p] & wr & is_as & data[UNIT[2:0]] & heard[p]);

        // Non-owner writes reach only the request and attention flops; the answer of a write carries no data.
        assign ans_d[p].ack    = strobe[p] & heard[p];
        assign ans_d[p].data   = wr ? '0 : rd;
        assign ans_d[p].parity = wr ? 1'b1 : ~^rd;
    end

    // ****************************************************************
    // Ownership arbitration
    // ****************************************************************
    // Port A wins a same-cycle tie; B keeps a request so it is served next.
    assign grant[0] = prog & neutral & qual[0];
    assign grant[1] = prog & neutral & qual[1] & ~qual[0];

    // The timeout behaves like a release from the owner: a pending request on the
    // other port is served at once, otherwise the drive falls back to neutral.
    // Locked modes never time out, because the owner there is fixed by the selector.
    assign timeout_hit = prog & ~neutral & (cnt_q == CNT_W'(TIMEOUT_CYCLES - 1));
    assign drop        = prog & ~neutral & ((|release_req) | timeout_hit);
    assign owner_touch = |(strobe & owner_is);
    assign init_any    = |init_acc;

    assign handed[0] = drop & owner_is[1] & want_q[0];
    assign handed[1] = drop & owner_is[0] & want_q[1];

    always_comb begin
        owner_d = owner_q;
        if (rdy_rise) begin
            owner_d = (mode_d == MODE_LOCK_A) ? OWN_A :
                      (mode_d == MODE_LOCK_B) ? OWN_B : OWN_NONE;
        end else if (grant[0]) begin
            owner_d = OWN_A;
        end else if (grant[1]) begin
            owner_d = OWN_B;
        end else if (handed[0]) begin
            owner_d = OWN_A;
        end else if (handed[1]) begin
            owner_d = OWN_B;
        end else if (drop) begin
            owner_d = OWN_NONE;
        end
    end

    // Only the ready edge loads the mode, so later selector motion is inert.
    assign mode_d = ~rdy_rise ? mode_q :
                    (sel_s_q == SELECT_A) ? MODE_LOCK_A :
                    (sel_s_q == SELECT_B) ? MODE_LOCK_B : MODE_PROG;

    // ****************************************************************
    // Command, flag and timer next state
    // ****************************************************************
    // At most one port can own the drive, so at most one owner control write can
    // be decoded in a cycle and a simple priority pick of its data is enough.
    wire logic own_wr   = |own_cs_wr;
    wire logic [1:0] wr_port = own_cs_wr[1] ? 2'h1 : 2'h0;
    wire logic [15:0] wr_data = req_s_q[wr_port[0]].data;

    // A new go from the owner outranks a completion seen in the same cycle.
    assign go_d = init_any ? 1'b0 :
                  (own_wr & ~(|release_req)) ? wr_data[GO_BIT] :
                  OP_DONE ? 1'b0 : go_q;
    assign func_d = init_any ? 5'h00 :
                    own_wr ? wr_data[FUNC_LSB +: FUNC_W] : func_q;

    assign vv_d   = vv_set | (vv_q & {2{mol_s_q}});
    assign attention_line_d = handed | (attention_line_q & ~attention_line_clr);
    assign want_d = want_set | (want_q & ~handed & ~grant);

    // The idle timer restarts on every owner access and while a command runs.
    assign cnt_d = (~prog | neutral | owner_touch | go_q | drop) ? '0 :
                   cnt_q + CNT_W'(1);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mode_q  <= RST_MODE;
            owner_q <= RST_OWNER;
            go_q    <= 1'b0;
            func_q  <= 5'h00;
            vv_q    <= 2'h0;
            attention_line_q  <= 2'h0;
            want_q  <= 2'h0;
            cnt_q   <= '0;
        end else if (CE) begin
            mode_q  <= mode_d;
            owner_q <= owner_d;
            go_q    <= go_d;
            func_q  <= func_d;
            vv_q    <= vv_d;
            attention_line_q  <= attention_line_d;
            want_q  <= want_d;
            cnt_q   <= cnt_d;
        end
    end

    // Answers are registered so both ports see clean one-cycle acknowledge pulses.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ans_q <= '{default: '0};
        end else if (CE) begin
            ans_q <= ans_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign A_ANS    = ans_q[0];
    assign B_ANS    = ans_q[1];
    assign A_ATTENTION_LINE   = attention_line_q[0];
    assign B_ATTENTION_LINE   = attention_line_q[1];
    assign GO       = go_q;
    assign FUNCTION = func_q;

endmodule // dual_port_drive_arbiter

// File: tb/dual_port_drive_arbiter_props.sv
`timescale 1ns/1ps
// ****************************************************************
// Port-level checks
// ****************************************************************
module dual_port_drive_arbiter_props
    import dual_port_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire req_t       A_REQ,
    input wire logic       OP_DONE,
    input wire ans_t       A_ANS,
    input wire ans_t       B_ANS,
    input wire logic       A_ATTENTION_LINE,
    input wire logic       GO,
    input wire logic [4:0] FUNCTION
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_status_rd;
        A_ANS.ack && !A_REQ.write && A_REQ.addr == ADDR_DRIVE_STATUS;
    endsequence
    sequence s_write_ack;
        A_ANS.ack && A_REQ.write;
    endsequence
    a_ack_single: assert property (A_ANS.ack |=> !A_ANS.ack)
        else $error("ack held longer than one cycle");
    a_ack_needs_req: assert property (A_ANS.ack |-> $past(A_REQ.valid, 2))
        else $error("ack without a held request");
    a_parity_odd: assert property (A_ANS.ack |-> A_ANS.parity == ~^A_ANS.data)
        else $error("answer parity not odd");
    a_write_zero: assert property (s_write_ack |-> A_ANS.data == '0 && A_ANS.parity)
        else $error("write answer not zero with parity one");
    a_ready_not_go: assert property (s_status_rd ##0 A_ANS.data[DPR_BIT] |->
        A_ANS.data[DRY_BIT] == !$past(GO))
        else $error("ready bit not inverse of go");
    a_foreign_zero: assert property (s_status_rd ##0 !A_ANS.data[DPR_BIT] |->
        A_ANS.data == '0)
        else $error("non-owner status not all zero");
    a_done_clears_go: assert property (OP_DONE && GO |=> !GO || A_ANS.ack || B_ANS.ack)
        else $error("go survived completion");
    a_func_by_write: assert property ($changed(FUNCTION) |->
        A_ANS.ack || B_ANS.ack || FUNCTION == '0)
        else $error("function changed without a write");
    a_reset_quiet: assert property ($fell(RST) |->
        !A_ANS.ack && !B_ANS.ack && !A_ATTENTION_LINE && !GO)
        else $error("outputs active after reset");
endmodule // dual_port_drive_arbiter_props

bind dual_port_drive_arbiter dual_port_drive_arbiter_props dual_port_drive_arbiter_props_i (
    .CLK_SYS, .RST, .A_REQ, .OP_DONE, .A_ANS, .B_ANS, .A_ATTENTION_LINE, .GO, .FUNCTION);

// File: tb/port_controller.sv
`timescale 1ns/1ps
// ****************************************************************
// Disk controller on one port
// ****************************************************************
module port_controller
    import dual_port_pkg::*;
(
    input  wire logic CLK,
    input  wire ans_t ANS,
    output req_t      REQ
);
    initial REQ = '0;
    // Fields settle three cycles ahead of valid since the drive sees them through
    // synchronisers; a locked-out port never answers, so the wait gives up after eight.
    task automatic access(input logic wr, input logic [4:0] ad, input logic [15:0] wd,
                          output ans_t rsp);
        int n;
        rsp = '0;
        REQ <= '{1'b0, wr, ad, wd};
        repeat (3) @(posedge CLK);
        REQ.valid <= 1'b1;
        for (n = 0; n < 8 && rsp.ack !== 1'b1; n++) begin
            @(posedge CLK);
            if (ANS.ack === 1'b1) rsp = ANS;
        end
        REQ <= '{1'b0, ~wr, ~ad, ~wd};
        repeat (3) @(posedge CLK);
    endtask
endmodule // port_controller

// File: tb/test_dual_port_drive_arbiter.sv
`timescale 1ns/1ps
// ****************************************************************
// Arbiter bench
// ****************************************************************
module test_dual_port_drive_arbiter;
    import dual_port_pkg::*;
    // The idle timer must outlast the longest stretch of foreign traffic in the scenarios,
    // eight accesses of ten cycles each, or ownership moves before it is checked.
    localparam longint TMO = 200;
    logic        clk_sys, rst, a_init, b_init, ready, done, a_attention_line, b_attention_line, go;
    logic [1:0]  sel;
    logic [31:0] lfsr;
    logic [4:0]  ad, func;
    req_t        a_req, b_req;
    ans_t        a_ans, b_ans, r;
    int          errors, checks_done;

    dual_port_drive_arbiter #(.TIMEOUT_CYCLES(TMO)) dual_port_drive_arbiter_i (
        .CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .A_REQ(a_req), .B_REQ(b_req),
        .A_INIT(a_init), .B_INIT(b_init), .PORT_SELECT(sel), .DRIVE_READY(ready),
        .MEDIUM_ONLINE(1'b1), .OP_DONE(done), .A_ANS(a_ans), .B_ANS(b_ans),
        .A_ATTENTION_LINE(a_attention_line), .B_ATTENTION_LINE(b_attention_line), .GO(go), .FUNCTION(func));
    port_controller ctl_a (.CLK(clk_sys), .ANS(a_ans), .REQ(a_req));
    port_controller ctl_b (.CLK(clk_sys), .ANS(b_ans), .REQ(b_req));

    function automatic logic [17:0] ans_exp(logic [15:0] d);
        return {1'b1, ~^d, d};
    endfunction
    function automatic logic [15:0] status_exp(logic vv, logic g, logic at);
        return {at, 2'h0, 1'b1, 2'h0, 1'b1, 1'b1, !g, vv, 6'h00};
    endfunction
    function automatic logic [15:0] cw(logic [4:0] f, logic g);
        return {10'h000, f, g};
    endfunction
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic pb, input logic wr, input logic [4:0] a, input logic [15:0] d);
        if (pb) ctl_b.access(wr, a, d, r);
        else ctl_a.access(wr, a, d, r);
    endtask
    task automatic pulse_init(input logic pb);
        if (pb) b_init <= 1'b1;
        else a_init <= 1'b1;
        repeat (4) @(posedge clk_sys);
        a_init <= 1'b0;
        b_init <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic restart(input logic [1:0] s);
        ready <= 1'b0;
        repeat (5) @(posedge clk_sys);
        sel <= s;
        repeat (5) @(posedge clk_sys);
        ready <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_sim();
    end
    initial begin
        int i;
        {rst, a_init, b_init, ready, done, sel, errors, checks_done} = '0;
        rst = 1'b1;
        lfsr = 32'hfcf6;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        restart(2'h0);
        acc(0, 1, ADDR_CONTROL_ONE, cw(CMD_PACK_ACK, 1)); check(r, ans_exp(0));
        acc(0, 0, ADDR_DRIVE_STATUS, 0); check(r, ans_exp(status_exp(1, 1, 0)));
        done <= 1'b1;
        @(posedge clk_sys);
        done <= 1'b0;
        @(posedge clk_sys);
        acc(0, 0, ADDR_DRIVE_STATUS, 0); check(r, ans_exp(status_exp(1, 0, 0)));
        acc(1, 0, ADDR_DRIVE_STATUS, 0); check(r, ans_exp(0));
        acc(1, 1, ADDR_CONTROL_ONE, cw(CMD_RELEASE, 1)); check(r, ans_exp(0));
        check(18'(func), 18'(CMD_PACK_ACK));
        for (i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            ad = (lfsr[4:0] == ADDR_ATTENTION_SUMMARY) ? 5'h02 : lfsr[4:0];
            acc(1, lfsr[5], ad, lfsr[31:16]); check(r, ans_exp(0));
        end
        acc(0, 0, ADDR_CONTROL_ONE, 0); check(r, ans_exp(16'h0800 | cw(CMD_PACK_ACK, 0)));
        acc(0, 1, ADDR_CONTROL_ONE, cw(CMD_RELEASE, 0)); check(r, ans_exp(0));
        check({16'h0, a_attention_line, b_attention_line}, 18'h1);
        acc(1, 0, ADDR_DRIVE_STATUS, 0); check(r, ans_exp(status_exp(0, 0, 1)));
        acc(0, 0, ADDR_CONTROL_ONE, 0); check(r, ans_exp(0));
        acc(1, 1, ADDR_CONTROL_ONE, cw(5'h0c, 1)); check(r, ans_exp(0));
        pulse_init(0);
        check({16'h0, go, b_attention_line}, 18'h3);
        pulse_init(1);
        check({16'h0, go, b_attention_line}, 18'h0);
        // Owner idles past the shortened timeout, so the drive must fall back to neutral.
        repeat (TMO + 20) @(posedge clk_sys);
        acc(0, 0, ADDR_CONTROL_ONE, 0); check(r, ans_exp(16'h0800));
        restart(SELECT_A);
        acc(1, 0, ADDR_DRIVE_STATUS, 0); check(r, 18'h0);
        acc(0, 0, ADDR_DRIVE_STATUS, 0); check(18'(r.data[PGM_BIT:DPR_BIT]), 18'h1);
        sel <= SELECT_B;
        repeat (10) @(posedge clk_sys);
        acc(1, 0, ADDR_CONTROL_ONE, 0); check(r, 18'h0);
        end_sim();
    end
endmodule // test_dual_port_drive_arbiter
